// ===== rtl/tlsm_top.sv
// Transformer load status monitor: load classification flags, event generation and a twelve-entry event log.
// Assumes phase currents and the millisecond stamp come from logic on sys_clk, so they are not synchronised.
`timescale 1ns/100ps
`include "tlsm_consts.svh"

// Function
// R1 - The no-load flag is high while the largest measured current is below the no-load limit.
// R2 - The HV inrush flag is high while the largest HV phase current exceeds the high overcurrent limit.
// R3 - The LV inrush flag is high while the largest LV phase current exceeds the high overcurrent limit.
// R4 - The normal-load flag is high only while the current is above the no-load limit and below the nominal limit.
// R5 - The overload flag is high while the current lies between the nominal and the high overcurrent limits.
// R6 - The heavy overload flag is high while the current exceeds the high overcurrent limit.
// R7 - Each of the six flags produces its own ON event when it rises and its own OFF event when it falls.
// R8 - Any change of a limit setting produces an event announcing that new transformer data is being calculated.
// R9 - The end of that recalculation produces an event announcing completion and a possible restart.
// R10 - The log keeps the latest twelve operations with one time-stamped entry per event.
// R11 - Each entry holds the millisecond time stamp, the event code and the six phase currents in per-unit.
// R12 - A new entry into a full log overwrites the oldest one.
module tlsm_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] hv_cur_l1,
  input wire logic [15:0] hv_cur_l2,
  input wire logic [15:0] hv_cur_l3,
  input wire logic [15:0] lv_cur_l1,
  input wire logic [15:0] lv_cur_l2,
  input wire logic [15:0] lv_cur_l3,
  input wire logic [47:0] stamp_ms,
  output logic flag_noload,
  output logic flag_hv_inrush,
  output logic flag_lv_inrush,
  output logic flag_load_normal,
  output logic flag_overload,
  output logic heavy_overload_flag,
  output logic irq
);

  logic [1:0] phase_reg;
  logic bus_req;
  logic acc_wr;
  logic acc_rd;
  logic set_wr;
  logic [15:0] lim_noload_reg;
  logic [15:0] lim_nominal_reg;
  logic [15:0] lim_high_reg;
  logic [15:0] hv_max;
  logic [15:0] lv_max;
  logic [15:0] all_max;
  logic [5:0] flags_next;
  logic [5:0] flags_reg;
  logic [13:0] ev_set;
  logic [13:0] pend_reg;
  logic [13:0] pop_mask;
  logic pop_valid;
  logic [3:0] pop_id;
  tlsm_pkg::tlsm_calc_state_t calc_state_reg;
  logic [7:0] calc_cnt_reg;
  logic calc_done;
  logic [3:0] wr_ptr_reg;
  logic [3:0] log_cnt_reg;
  logic [3:0] log_sel_reg;
  logic [3:0] rd_addr;
  tlsm_pkg::tlsm_entry_t wr_entry;
  tlsm_pkg::tlsm_entry_t rd_entry;
  logic [13:0] irq_stat_reg;
  logic [13:0] irq_mask_reg;
  logic [31:0] rd_mux;
  logic log_hit;

  // Byte-lane merge for the sixteen-bit wide registers.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Largest of three phase currents.
  function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction : max3

  // Reduces a value below twenty-four into the twelve log slots.
  function automatic logic [3:0] mod12(input logic [4:0] v);
    logic [4:0] r;
    r = (v >= {1'b0, `TLSM_LOG_DEPTH}) ? v - {1'b0, `TLSM_LOG_DEPTH} : v;
    mod12 = r[3:0];
  endfunction : mod12

  // Every access answers in its third cycle; the middle cycle lets the log memory settle after a select write.
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req && (phase_reg != `TLSM_BUS_ACK_PHASE);
  assign acc_wr = avs_write && (phase_reg == `TLSM_BUS_ACK_PHASE);
  assign acc_rd = avs_read && (phase_reg == `TLSM_BUS_ACK_PHASE);
  assign set_wr = acc_wr && (avs_address == `TLSM_OFF_LIM_NOLOAD || avs_address == `TLSM_OFF_LIM_NOMINAL ||
                             avs_address == `TLSM_OFF_LIM_HIGH);

  // Bus phase counter.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !bus_req || phase_reg == `TLSM_BUS_ACK_PHASE)
    begin
      phase_reg <= 2'h0;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Limit settings and software controls.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lim_noload_reg <= `TLSM_LIM_NOLOAD_RST;
      lim_nominal_reg <= `TLSM_LIM_NOMINAL_RST;
      lim_high_reg <= `TLSM_LIM_HIGH_RST;
      irq_mask_reg <= 14'h0000;
      log_sel_reg <= 4'h0;
    end
    else if (acc_wr)
    begin
      unique case (avs_address)
        `TLSM_OFF_LIM_NOLOAD: lim_noload_reg <= merge16(lim_noload_reg, avs_writedata, avs_byteenable);
        `TLSM_OFF_LIM_NOMINAL: lim_nominal_reg <= merge16(lim_nominal_reg, avs_writedata, avs_byteenable);
        `TLSM_OFF_LIM_HIGH: lim_high_reg <= merge16(lim_high_reg, avs_writedata, avs_byteenable);
        `TLSM_OFF_IRQ_MASK: irq_mask_reg <= 14'(merge16({2'h0, irq_mask_reg}, avs_writedata, avs_byteenable));
        `TLSM_OFF_LOG_SEL: log_sel_reg <= 4'(merge16({12'h000, log_sel_reg}, avs_writedata, avs_byteenable));
        default: ;
      endcase
    end
  end

  // Classification uses the largest phase on each side; only equality with the no-load limit falls between the bands.
  always_comb
  begin
    hv_max = max3(hv_cur_l1, hv_cur_l2, hv_cur_l3);
    lv_max = max3(lv_cur_l1, lv_cur_l2, lv_cur_l3);
    all_max = (hv_max > lv_max) ? hv_max : lv_max;
    flags_next[`TLSM_FLAG_NOLOAD] = all_max < lim_noload_reg; // [R1]
    flags_next[`TLSM_FLAG_HV_INRUSH] = hv_max > lim_high_reg; // [R2]
    flags_next[`TLSM_FLAG_LV_INRUSH] = lv_max > lim_high_reg; // [R3]
    flags_next[`TLSM_FLAG_NORMAL] = (all_max > lim_noload_reg) && (all_max < lim_nominal_reg); // [R4]
    flags_next[`TLSM_FLAG_OVERLOAD] = (all_max >= lim_nominal_reg) && (all_max <= lim_high_reg); // [R5]
    flags_next[`TLSM_FLAG_HEAVY] = all_max > lim_high_reg; // [R6]
  end

  // Flags are registered once per cycle.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flags_reg <= 6'h00;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  assign flag_noload = flags_reg[`TLSM_FLAG_NOLOAD];
  assign flag_hv_inrush = flags_reg[`TLSM_FLAG_HV_INRUSH];
  assign flag_lv_inrush = flags_reg[`TLSM_FLAG_LV_INRUSH];
  assign flag_load_normal = flags_reg[`TLSM_FLAG_NORMAL];
  assign flag_overload = flags_reg[`TLSM_FLAG_OVERLOAD];
  assign heavy_overload_flag = flags_reg[`TLSM_FLAG_HEAVY];

  // Edge detection: event 2k is flag k ON, event 2k+1 is flag k OFF.
  for (genvar k = 0; k < `TLSM_NUM_FLAGS; k++)
  begin : g_edge
    assign ev_set[2 * k] = flags_next[k] & ~flags_reg[k]; // [R7]
    assign ev_set[2 * k + 1] = ~flags_next[k] & flags_reg[k]; // [R7]
  end
  assign ev_set[`TLSM_EV_CALC_START] = set_wr; // [R8]
  assign ev_set[`TLSM_EV_CALC_DONE] = calc_done; // [R9]

  // Recalculation timer; a further setting change restarts it.
  assign calc_done = (calc_state_reg == tlsm_pkg::TLSM_CALC_RUN) && (calc_cnt_reg == 8'h00) && !set_wr;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      calc_state_reg <= tlsm_pkg::TLSM_CALC_IDLE;
      calc_cnt_reg <= 8'h00;
    end
    else
    begin
      unique case (calc_state_reg)
        tlsm_pkg::TLSM_CALC_IDLE:
        begin
          if (set_wr)
          begin
            calc_state_reg <= tlsm_pkg::TLSM_CALC_RUN;
            calc_cnt_reg <= `TLSM_CALC_CYCLES - 8'h01;
          end
        end
        tlsm_pkg::TLSM_CALC_RUN:
        begin
          if (set_wr)
          begin
            calc_cnt_reg <= `TLSM_CALC_CYCLES - 8'h01;
          end
          else if (calc_cnt_reg == 8'h00)
          begin
            calc_state_reg <= tlsm_pkg::TLSM_CALC_IDLE; // [R9]
          end
          else
          begin
            calc_cnt_reg <= calc_cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // Lowest pending event code goes to the log first; several may arise in one cycle.
  always_comb
  begin
    pop_valid = 1'b0;
    pop_id = 4'h0;
    for (int i = `TLSM_NUM_EVENTS - 1; i >= 0; i--)
    begin
      if (pend_reg[i])
      begin
        pop_valid = 1'b1;
        pop_id = i[3:0];
      end
    end
    pop_mask = pop_valid ? (14'h0001 << pop_id) : 14'h0000;
  end

  // New events win over the pop of the same code.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_reg <= 14'h0000;
    end
    else
    begin
      pend_reg <= (pend_reg & ~pop_mask) | ev_set;
    end
  end

  // Entry content is captured at the moment the event is logged.
  always_comb
  begin
    wr_entry.stamp = stamp_ms; // [R11]
    wr_entry.ev = pop_id; // [R11]
    wr_entry.hv_l1 = hv_cur_l1;
    wr_entry.hv_l2 = hv_cur_l2;
    wr_entry.hv_l3 = hv_cur_l3;
    wr_entry.lv_l1 = lv_cur_l1;
    wr_entry.lv_l2 = lv_cur_l2;
    wr_entry.lv_l3 = lv_cur_l3;
  end

  // Circular log pointer; when full the write slot is the oldest entry.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 4'h0;
      log_cnt_reg <= 4'h0;
    end
    else if (pop_valid)
    begin
      wr_ptr_reg <= mod12({1'b0, wr_ptr_reg} + 5'h01); // [R10]
      log_cnt_reg <= (log_cnt_reg == `TLSM_LOG_DEPTH) ? `TLSM_LOG_DEPTH : log_cnt_reg + 4'h1; // [R12]
    end
  end

  // Select 0 is the newest entry.
  assign rd_addr = mod12({1'b0, wr_ptr_reg} + `TLSM_LOG_LAST - {1'b0, log_sel_reg});
  assign log_hit = log_sel_reg < log_cnt_reg;

  tlsm_log_mem u_log_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(pop_valid),
    .wr_addr(wr_ptr_reg),
    .wr_data(wr_entry),
    .rd_addr(rd_addr),
    .rd_data(rd_entry)
  );

  // Sticky interrupt status; a read clears only the bits it returned, so a late event is never lost.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_stat_reg <= 14'h0000;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~((acc_rd && avs_address == `TLSM_OFF_IRQ_STAT) ? avs_readdata[13:0] :
                       14'h0000)) | ev_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    unique case (avs_address)
      `TLSM_OFF_LIM_NOLOAD: rd_mux = {16'h0000, lim_noload_reg};
      `TLSM_OFF_LIM_NOMINAL: rd_mux = {16'h0000, lim_nominal_reg};
      `TLSM_OFF_LIM_HIGH: rd_mux = {16'h0000, lim_high_reg};
      `TLSM_OFF_STATUS: rd_mux = {23'h000000, calc_state_reg == tlsm_pkg::TLSM_CALC_RUN, 2'h0, flags_reg};
      `TLSM_OFF_IRQ_STAT: rd_mux = {18'h00000, irq_stat_reg};
      `TLSM_OFF_IRQ_MASK: rd_mux = {18'h00000, irq_mask_reg};
      `TLSM_OFF_LOG_SEL: rd_mux = {28'h0000000, log_sel_reg};
      `TLSM_OFF_LOG_COUNT: rd_mux = {28'h0000000, log_cnt_reg};
      `TLSM_OFF_LOG_W0: rd_mux = log_hit ? rd_entry.stamp[31:0] : 32'h00000000;
      `TLSM_OFF_LOG_W1: rd_mux = log_hit ? {12'h000, rd_entry.ev, rd_entry.stamp[47:32]} : 32'h00000000;
      `TLSM_OFF_LOG_W2: rd_mux = log_hit ? {rd_entry.hv_l2, rd_entry.hv_l1} : 32'h00000000;
      `TLSM_OFF_LOG_W3: rd_mux = log_hit ? {rd_entry.lv_l1, rd_entry.hv_l3} : 32'h00000000;
      `TLSM_OFF_LOG_W4: rd_mux = log_hit ? {rd_entry.lv_l3, rd_entry.lv_l2} : 32'h00000000;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data are captured in the second cycle and held through the answer.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (avs_read && phase_reg == 2'h1)
    begin
      avs_readdata <= rd_mux;
    end
  end

  AST_NOLOAD: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    (all_max < lim_noload_reg) |=> flag_noload) else $error("no-load flag missing");
  AST_HV_INRUSH: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    (hv_max > lim_high_reg) |=> flag_hv_inrush) else $error("HV inrush flag missing");
  AST_LV_INRUSH: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    (lv_max <= lim_high_reg) |=> !flag_lv_inrush) else $error("LV inrush flag spurious");
  AST_NORMAL: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    flag_load_normal |-> (flag_noload == 1'b0 && flag_overload == 1'b0 && heavy_overload_flag == 1'b0))
    else $error("normal flag overlaps another band");
  AST_OVERLOAD: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (all_max >= lim_nominal_reg && all_max <= lim_high_reg) |=> flag_overload) else $error("overload flag missing");
  AST_HEAVY: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    heavy_overload_flag |-> (flag_hv_inrush || flag_lv_inrush)) else $error("heavy flag without an inrush side");
  AST_FLAG_EVENTS: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    ($rose(flag_noload) |-> pend_reg[0]) and ($fell(heavy_overload_flag) |-> pend_reg[11]))
    else $error("flag edge produced no event");
  AST_CALC_START: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    set_wr |=> pend_reg[`TLSM_EV_CALC_START] && calc_state_reg == tlsm_pkg::TLSM_CALC_RUN)
    else $error("setting change produced no start event");
  AST_CALC_DONE: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    (calc_state_reg == tlsm_pkg::TLSM_CALC_IDLE) ##1 (set_wr && calc_state_reg == tlsm_pkg::TLSM_CALC_IDLE)
    ##1 (!set_wr) [*8] ##1 (!set_wr) [*8] |=> pend_reg[`TLSM_EV_CALC_DONE]) else $error("no completion event");
  AST_LOG_GROW: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    (pop_valid && log_cnt_reg < `TLSM_LOG_DEPTH) |=> log_cnt_reg == $past(log_cnt_reg) + 4'h1)
    else $error("log count did not grow");
  AST_LOG_CONTENT: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    pop_valid |=> (u_log_mem.mem[$past(wr_ptr_reg)].ev == $past(pop_id) &&
    u_log_mem.mem[$past(wr_ptr_reg)].stamp == $past(stamp_ms))) else $error("log entry content wrong");
  AST_LOG_WRAP: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
    (pop_valid && log_cnt_reg == `TLSM_LOG_DEPTH) |=> (log_cnt_reg == `TLSM_LOG_DEPTH &&
    wr_ptr_reg == mod12({1'b0, $past(wr_ptr_reg)} + 5'h01))) else $error("full log did not overwrite oldest");

  COV_HEAVY_ON: cover property (@(posedge sys_clk) disable iff (rst) $rose(heavy_overload_flag));
  COV_CALC_DONE: cover property (@(posedge sys_clk) disable iff (rst) calc_done);
  COV_LOG_WRAP: cover property (@(posedge sys_clk) disable iff (rst) pop_valid && log_cnt_reg == `TLSM_LOG_DEPTH);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));

endmodule : tlsm_top

// ===== common/tlsm_consts.svh
// Offsets, field positions, reset values and timing counts of the transformer load status monitor.
// Assumes byte addressing on a 32-bit Avalon-MM slave with word-aligned registers.
`ifndef TLSM_CONSTS_SVH
`define TLSM_CONSTS_SVH

`define TLSM_OFF_LIM_NOLOAD 6'h00
`define TLSM_OFF_LIM_NOMINAL 6'h04
`define TLSM_OFF_LIM_HIGH 6'h08
`define TLSM_OFF_STATUS 6'h0C
`define TLSM_OFF_IRQ_STAT 6'h10
`define TLSM_OFF_IRQ_MASK 6'h14
`define TLSM_OFF_LOG_SEL 6'h18
`define TLSM_OFF_LOG_COUNT 6'h1C
`define TLSM_OFF_LOG_W0 6'h20
`define TLSM_OFF_LOG_W1 6'h24
`define TLSM_OFF_LOG_W2 6'h28
`define TLSM_OFF_LOG_W3 6'h2C
`define TLSM_OFF_LOG_W4 6'h30

`define TLSM_NUM_FLAGS 6
`define TLSM_NUM_EVENTS 14
`define TLSM_FLAG_NOLOAD 0
`define TLSM_FLAG_HV_INRUSH 1
`define TLSM_FLAG_LV_INRUSH 2
`define TLSM_FLAG_NORMAL 3
`define TLSM_FLAG_OVERLOAD 4
`define TLSM_FLAG_HEAVY 5
`define TLSM_EV_CALC_START 12
`define TLSM_EV_CALC_DONE 13
`define TLSM_STATUS_BUSY_BIT 8

`define TLSM_LOG_DEPTH 4'hC
`define TLSM_LOG_LAST 5'h0B
`define TLSM_CALC_CYCLES 8'h10
`define TLSM_BUS_ACK_PHASE 2'h2

`define TLSM_LIM_NOLOAD_RST 16'h0019
`define TLSM_LIM_NOMINAL_RST 16'h0100
`define TLSM_LIM_HIGH_RST 16'h0300

`endif

// ===== common/tlsm_pkg.sv
// Types shared by the transformer load status monitor files.
// Assumes currents in unsigned 8.8 per-unit and a millisecond time count.
package tlsm_pkg;

  typedef enum logic {TLSM_CALC_IDLE, TLSM_CALC_RUN} tlsm_calc_state_t;

  typedef struct packed {
    logic [47:0] stamp;
    logic [3:0] ev;
    logic [15:0] hv_l1;
    logic [15:0] hv_l2;
    logic [15:0] hv_l3;
    logic [15:0] lv_l1;
    logic [15:0] lv_l2;
    logic [15:0] lv_l3;
  } tlsm_entry_t;

endpackage : tlsm_pkg

// ===== rtl/tlsm_log_mem.sv
// Twelve-entry event log storage with one write port and a registered read port.
// Assumes the caller keeps both addresses below twelve.
`timescale 1ns/100ps
`include "tlsm_consts.svh"

module tlsm_log_mem (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire tlsm_pkg::tlsm_entry_t wr_data,
  input wire logic [3:0] rd_addr,
  output tlsm_pkg::tlsm_entry_t rd_data
);

  tlsm_pkg::tlsm_entry_t mem [0:11];

  // Storage has no reset; an unwritten slot is masked by the entry count upstream.
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data always come from a register so the bus mux sees a clean timing path.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : tlsm_log_mem

// ===== verif/tlsm_cur_src.sv
// Behavioural source of the six phase currents and of the millisecond stamp.
// Assumes the bench sets one level per side; every output follows on sys_clk.
`timescale 1ns/100ps

module tlsm_cur_src (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] set_hv,
  input wire logic [15:0] set_lv,
  output logic [15:0] hv_l1,
  output logic [15:0] hv_l2,
  output logic [15:0] hv_l3,
  output logic [15:0] lv_l1,
  output logic [15:0] lv_l2,
  output logic [15:0] lv_l3,
  output logic [47:0] stamp
);
  // Phase 1 carries the level and the others fall away, so phase 1 is always the largest.
  always_ff @(posedge sys_clk)
  begin
    hv_l1 <= set_hv;
    hv_l2 <= set_hv >> 1;
    hv_l3 <= set_hv >> 2;
    lv_l1 <= set_lv;
    lv_l2 <= set_lv >> 1;
    lv_l3 <= set_lv >> 2;
  end

  // The stamp steps every cycle, so entries logged a cycle apart differ by one.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stamp <= 48'h0;
    end
    else
    begin
      stamp <= stamp + 48'h1;
    end
  end
endmodule : tlsm_cur_src

// ===== verif/tb.sv
// Self-checking bench of the transformer load status monitor.
// Assumes the current source model beside it and the fixed three-cycle bus answer.
`timescale 1ns/100ps
`include "tlsm_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) \
  begin fails++; $display("Error %0t: got %h exp %h", $time, (a), (b)); end end

module tb;
  logic sys_clk;
  logic rst;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] set_hv;
  logic [15:0] set_lv;
  logic [15:0] c1, c2, c3, c4, c5, c6;
  logic [47:0] stamp;
  logic [5:0] flags;
  logic irq;
  logic [31:0] r;
  logic [31:0] s0;
  logic [15:0] h;
  logic [15:0] l;
  logic [15:0] corner [8] = '{16'h0018, 16'h0019, 16'h001A, 16'h00FF, 16'h0100, 16'h0300, 16'h0301, 16'h0000};
  // Event codes expected two to five entries back: overload ON, normal OFF, overload OFF, normal ON.
  logic [3:0] older [4] = '{4'h8, 4'h7, 4'h9, 4'h6};
  int fails = 0;
  int comparisons = 0;

  tlsm_cur_src src (.sys_clk(sys_clk), .rst(rst), .set_hv(set_hv), .set_lv(set_lv), .hv_l1(c1), .hv_l2(c2),
    .hv_l3(c3), .lv_l1(c4), .lv_l2(c5), .lv_l3(c6), .stamp(stamp));

  tlsm_top DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hv_cur_l1(c1), .hv_cur_l2(c2), .hv_cur_l3(c3), .lv_cur_l1(c4),
    .lv_cur_l2(c5), .lv_cur_l3(c6), .stamp_ms(stamp), .flag_noload(flags[0]), .flag_hv_inrush(flags[1]),
    .flag_lv_inrush(flags[2]), .flag_load_normal(flags[3]), .flag_overload(flags[4]),
    .heavy_overload_flag(flags[5]), .irq(irq));

  // The clock toggles every half period of 4 ns.
  always #4 sys_clk = ~sys_clk;

  // Expected flags for the default limits; equality with the no-load limit leaves every band flag low.
  function automatic logic [5:0] expf(input logic [15:0] hv, input logic [15:0] lv);
    logic [15:0] m;
    m = (hv > lv) ? hv : lv;
    expf = {m > 16'h0300, m >= 16'h0100 && m <= 16'h0300, m > 16'h0019 && m < 16'h0100,
      lv > 16'h0300, hv > 16'h0300, m < 16'h0019};
  endfunction : expf

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // One Avalon access; the request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= dat;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      fails++;
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [5:0] adr, input logic [31:0] dat);
    logic [31:0] x;
    bus(1'b1, adr, dat, x);
  endtask : wr

  task automatic rd(input logic [5:0] adr, output logic [31:0] rdat);
    bus(1'b0, adr, 32'h0, rdat);
  endtask : rd

  // Selects a log entry, newest first, and reads one of its words.
  task automatic lw(input logic [3:0] sel, input logic [5:0] adr, output logic [31:0] rdat);
    wr(`TLSM_OFF_LOG_SEL, {28'h0, sel});
    rd(adr, rdat);
  endtask : lw

  // Sets both side levels and lets source, classification and flag register settle.
  task automatic lvl(input logic [15:0] hv, input logic [15:0] lv);
    @(posedge sys_clk);
    set_hv <= hv;
    set_lv <= lv;
    repeat (4) @(posedge sys_clk);
  endtask : lvl

  // A hang anywhere ends the run as a failure.
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end

  // Main sequence: registers, random classification, events and log, mask, recalculation, full log.
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    set_hv = 16'h0000;
    set_lv = 16'h0000;
    void'($urandom(41497));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(`TLSM_OFF_LIM_NOLOAD, r);
    `CHK(r[15:0], `TLSM_LIM_NOLOAD_RST)
    rd(`TLSM_OFF_LIM_NOMINAL, r);
    `CHK(r[15:0], `TLSM_LIM_NOMINAL_RST)
    rd(`TLSM_OFF_LIM_HIGH, r);
    `CHK(r[15:0], `TLSM_LIM_HIGH_RST)
    rd(6'h3C, r);
    `CHK(r, 32'h0)
    wr(`TLSM_OFF_STATUS, 32'h3F);
    rd(`TLSM_OFF_STATUS, r);
    `CHK(r, 32'h1)
    rd(`TLSM_OFF_LOG_COUNT, r);
    `CHK(r, 32'h1)
    lw(4'h0, `TLSM_OFF_LOG_W1, r);
    `CHK(r[19:16], 4'h0)
    rd(`TLSM_OFF_IRQ_STAT, r);
    `CHK(r, 32'h1)
    wr(`TLSM_OFF_IRQ_MASK, 32'h3FFF);
    rd(`TLSM_OFF_IRQ_MASK, r);
    `CHK(r, 32'h3FFF)
    for (int i = 0; i < 40; i++)
    begin
      h = (i % 2) ? corner[$urandom % 8] : 16'($urandom % 1024);
      l = (i % 3) ? corner[$urandom % 8] : 16'($urandom % 1024);
      lvl(h, l);
      `CHK(flags, expf(h, l))
      rd(`TLSM_OFF_STATUS, r);
      `CHK(r[5:0], expf(h, l))
    end
    lvl(16'h0100, 16'h0080);
    repeat (20) @(posedge sys_clk);
    rd(`TLSM_OFF_IRQ_STAT, r);
    lvl(16'h0050, 16'h0040);
    repeat (10) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    rd(`TLSM_OFF_IRQ_STAT, r);
    `CHK(r, 32'h0240)
    // The clear lands at the answering edge, so the level is looked at one edge later.
    @(posedge sys_clk);
    `CHK(irq, 1'b0)
    lw(4'h0, `TLSM_OFF_LOG_W1, r);
    `CHK(r[19:16], 4'h9)
    lw(4'h1, `TLSM_OFF_LOG_W1, r);
    `CHK(r[19:16], 4'h6)
    lw(4'h0, `TLSM_OFF_LOG_W0, s0);
    lw(4'h1, `TLSM_OFF_LOG_W0, r);
    `CHK(s0 - r, 32'h1)
    lw(4'h0, `TLSM_OFF_LOG_W2, r);
    `CHK(r, {16'h0028, 16'h0050})
    lw(4'h0, `TLSM_OFF_LOG_W3, r);
    `CHK(r, {16'h0040, 16'h0014})
    lw(4'h0, `TLSM_OFF_LOG_W4, r);
    `CHK(r, {16'h0010, 16'h0020})
    wr(`TLSM_OFF_IRQ_MASK, 32'h0);
    lvl(16'h0100, 16'h0080);
    repeat (10) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wr(`TLSM_OFF_IRQ_MASK, 32'h3FFF);
    #1;
    `CHK(irq, 1'b1)
    rd(`TLSM_OFF_IRQ_STAT, r);
    `CHK(r, 32'h0180)
    wr(`TLSM_OFF_LIM_NOLOAD, 32'h0020);
    rd(`TLSM_OFF_STATUS, r);
    `CHK(r[8], 1'b1)
    repeat (30) @(posedge sys_clk);
    rd(`TLSM_OFF_STATUS, r);
    `CHK(r[8], 1'b0)
    rd(`TLSM_OFF_IRQ_STAT, r);
    `CHK(r, 32'h3000)
    lw(4'h0, `TLSM_OFF_LOG_W1, r);
    `CHK(r[19:16], 4'hD)
    lw(4'h1, `TLSM_OFF_LOG_W1, r);
    `CHK(r[19:16], 4'hC)
    // The log has wrapped by now, so older entries must still come back in order.
    for (int k = 0; k < 4; k++)
    begin
      lw(4'(k + 2), `TLSM_OFF_LOG_W1, r);
      `CHK(r[19:16], older[k])
    end
    rd(`TLSM_OFF_LOG_COUNT, r);
    `CHK(r, 32'hC)
    lw(4'hC, `TLSM_OFF_LOG_W1, r);
    `CHK(r, 32'h0)
    end_of_test();
  end
endmodule : tb
